// [src/pdm_pkg.sv]
// Constants and types shared by the pin drive-mode port
package pdm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_OUT_VALUE = 8'h00;
	localparam logic [7:0] OFF_PIN_STATE = 8'h04;
	localparam logic [7:0] OFF_DM0 = 8'h08;
	localparam logic [7:0] OFF_DM1 = 8'h0C;
	localparam logic [7:0] OFF_DM2 = 8'h10;
	localparam logic [7:0] OFF_HW_SEL = 8'h14;
	localparam logic [7:0] OFF_IN_EN = 8'h18;
	localparam logic [7:0] OFF_REGULATED = 8'h1C;
	localparam logic [7:0] OFF_INT_RISE = 8'h20;
	localparam logic [7:0] OFF_INT_FALL = 8'h24;
	localparam logic [7:0] OFF_INT_STATUS = 8'h28;
	localparam logic [7:0] OFF_USB_EN = 8'h2C;
	localparam logic [7:0] OFF_PIN_BASE = 8'h40;

	// Per-pin register field positions
	localparam int PIN_OUT_BIT = 0;
	localparam int PIN_DM_LSB = 1;
	localparam int PIN_HW_SEL_BIT = 4;
	localparam int PIN_IN_EN_BIT = 5;
	localparam int PIN_STATE_BIT = 6;
	localparam int PIN_RISE_BIT = 7;
	localparam int PIN_FALL_BIT = 8;

	// Drive modes
	localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] DM_RES_UP = 3'h2;
	localparam logic [2:0] DM_RES_DOWN = 3'h3;
	localparam logic [2:0] DM_OD_LOW = 3'h4;
	localparam logic [2:0] DM_OD_HIGH = 3'h5;
	localparam logic [2:0] DM_STRONG = 3'h6;
	localparam logic [2:0] DM_RES_BOTH = 3'h7;

	// Reset values of the other registers
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

	// Driver state of one pin
	typedef struct packed {
		logic strong_hi;
		logic strong_lo;
		logic res_hi;
		logic res_lo;
		logic in_en;
	} pdm_drive_t;

endpackage

// [src/pdm_port.sv]
// Pin drive-mode port: drive decode, pin state, edge interrupts, APB registers
// Operation
// - Every pin has its own three-bit drive mode field, eight modes on general and special pins.
// - Mode 0 is the reset default: no driver, no digital input on general and special pins; USB pins drive strong low for 0.
// - High-impedance analog mode gives no digital input at all.
// - Mode 1: driver off, input buffer on.
// - Mode 2 resistive high/strong low; mode 3 strong high/resistive low; input usable.
// - Mode 4 floats for 1, strong low for 0.
// - Mode 5 strong high for 1, floats for 0; open-drain input usable.
// - Mode 6 strong high for 1, strong low for 0.
// - Mode 7 resistive high for 1, resistive low for 0.
// - Special pins in regulated mode have no resistive drive.
// - Output value from system signal when hardware select set, else data register.
// - Pin input updates pin state and feeds system when input enabled.
// - Pin state register is separate from the output data register.
// - Port-wide and per-pin registers reach the same state, except USB pin mode bits, which only per-pin writes change.
// - Interrupt per pin on rising, falling or both edges.
// - One interrupt line for the whole port.
// - Port reset state is set by the user.
// - USB pin, pull 0 drive 0: float for 1, strong low for 0.
// - USB pin drive 1 strong both; pull 1 drive 0 resistive high, strong low.
// - USB pins in USB mode ignore drive and pull bits.
// - Port-wide mode writes leave USB pin mode bits unchanged.
// - Selected edge sets the pin status bit and requests an interrupt.
`timescale 1ns/10ps
module pdm_port #(
	parameter int NUM_PINS = 8,
	parameter logic [7:0] SPECIAL_MASK = 8'h00,
	parameter logic [7:0] USB_MASK = 8'hC0,
	parameter logic [7:0] RESET_OUT = 8'h00,
	parameter logic [23:0] RESET_DM = 24'h000000
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Routed digital system
	input wire logic [NUM_PINS-1:0] sys_out,
	output logic [NUM_PINS-1:0] sys_in,
	// USB core drive for the USB-capable pins
	input wire logic [NUM_PINS-1:0] usb_tx_val,
	input wire logic [NUM_PINS-1:0] usb_tx_oe_n,
	// Pins
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe_n,
	output logic [NUM_PINS-1:0] pin_pull_up,
	output logic [NUM_PINS-1:0] pin_pull_dn,
	// Port interrupt
	output logic port_irq
);

	// Programmed state
	logic [NUM_PINS-1:0] output_value_reg;
	logic [2:0] drive_mode_field [NUM_PINS];
	logic [NUM_PINS-1:0] hw_output_select;
	logic [NUM_PINS-1:0] in_enable;
	logic [NUM_PINS-1:0] regulated;
	logic [NUM_PINS-1:0] int_rise;
	logic [NUM_PINS-1:0] int_fall;
	logic [NUM_PINS-1:0] int_status;
	logic usb_enable;

	// Pin input path
	logic [NUM_PINS-1:0] pin_sync1;
	logic [NUM_PINS-1:0] pin_sync2;
	logic [NUM_PINS-1:0] pin_state_reg;
	logic [NUM_PINS-1:0] pin_state_prev;
	logic [NUM_PINS-1:0] edge_event;

	// Drive decode
	pdm_pkg::pdm_drive_t drive [NUM_PINS];
	logic [NUM_PINS-1:0] port_output_value;

	// Bus decode
	logic access;
	logic wr_en;
	logic rd_en;
	logic pin_hit;
	logic [7:0] pin_index;
	logic [31:0] pin_word;
	logic mapped;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	// Drive state of a general or special pin for one mode and data value
	function automatic pdm_pkg::pdm_drive_t decode_mode(input logic [2:0] dm, input logic v,
			input logic no_res);
		pdm_pkg::pdm_drive_t d;
		d = '0;
		d.in_en = 1'b1;
		unique case (dm)
			pdm_pkg::DM_HIZ_ANALOG: begin
				d.in_en = 1'b0;
			end
			pdm_pkg::DM_HIZ_DIGITAL: begin
				d.in_en = 1'b1;
			end
			pdm_pkg::DM_RES_UP: begin
				d.res_hi = v;
				d.strong_lo = !v;
			end
			pdm_pkg::DM_RES_DOWN: begin
				d.strong_hi = v;
				d.res_lo = !v;
			end
			pdm_pkg::DM_OD_LOW: begin
				d.strong_lo = !v;
			end
			pdm_pkg::DM_OD_HIGH: begin
				d.strong_hi = v;
			end
			pdm_pkg::DM_STRONG: begin
				d.strong_hi = v;
				d.strong_lo = !v;
			end
			pdm_pkg::DM_RES_BOTH: begin
				d.res_hi = v;
				d.res_lo = !v;
			end
		endcase
		// Regulated special pins cannot pull through the series resistor
		if (no_res) begin
			d.res_hi = 1'b0;
			d.res_lo = 1'b0;
		end
		return d;
	endfunction

	// Reduced scheme of the USB-capable pins: bit 0 drive, bit 1 pull
	function automatic pdm_pkg::pdm_drive_t decode_usb(input logic [2:0] dm, input logic v);
		pdm_pkg::pdm_drive_t d;
		d = '0;
		d.in_en = 1'b1;
		d.strong_lo = !v;
		if (dm[0]) begin
			d.strong_hi = v;
		end else if (dm[1]) begin
			d.res_hi = v;
		end
		return d;
	endfunction

	// APB decode; always ready, no wait states
	assign access = psel && penable;
	assign wr_en = access && pwrite && ce;
	assign rd_en = access && !pwrite && ce;
	assign pready = access;
	assign pin_hit = (paddr >= pdm_pkg::OFF_PIN_BASE) && (paddr[1:0] == 2'h0) &&
		(((paddr - pdm_pkg::OFF_PIN_BASE) >> 2) < 8'(NUM_PINS));
	assign pin_index = 8'((paddr - pdm_pkg::OFF_PIN_BASE) >> 2);
	assign mapped = pin_hit || hit(paddr, pdm_pkg::OFF_OUT_VALUE) || hit(paddr, pdm_pkg::OFF_PIN_STATE) ||
		hit(paddr, pdm_pkg::OFF_DM0) || hit(paddr, pdm_pkg::OFF_DM1) || hit(paddr, pdm_pkg::OFF_DM2) ||
		hit(paddr, pdm_pkg::OFF_HW_SEL) || hit(paddr, pdm_pkg::OFF_IN_EN) ||
		hit(paddr, pdm_pkg::OFF_REGULATED) || hit(paddr, pdm_pkg::OFF_INT_RISE) ||
		hit(paddr, pdm_pkg::OFF_INT_FALL) || hit(paddr, pdm_pkg::OFF_INT_STATUS) ||
		hit(paddr, pdm_pkg::OFF_USB_EN);
	assign pslverr = access && !mapped;

	// Output data register, port and pin views
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_value_reg <= RESET_OUT[NUM_PINS-1:0];
		end else if (wr_en) begin
			if (hit(paddr, pdm_pkg::OFF_OUT_VALUE)) begin
				output_value_reg <= pwdata[NUM_PINS-1:0];
			end else if (pin_hit) begin
				output_value_reg[pin_index[2:0]] <= pwdata[pdm_pkg::PIN_OUT_BIT];
			end
		end
	end

	// Drive mode fields, port bit planes and per-pin form
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				drive_mode_field[i] <= RESET_DM[3*i +: 3];
			end
		end else if (wr_en) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (!USB_MASK[i]) begin
					if (hit(paddr, pdm_pkg::OFF_DM0)) begin
						drive_mode_field[i][0] <= pwdata[i];
					end
					if (hit(paddr, pdm_pkg::OFF_DM1)) begin
						drive_mode_field[i][1] <= pwdata[i];
					end
					if (hit(paddr, pdm_pkg::OFF_DM2)) begin
						drive_mode_field[i][2] <= pwdata[i];
					end
				end
				if (pin_hit && pin_index == 8'(i)) begin
					drive_mode_field[i] <= pwdata[pdm_pkg::PIN_DM_LSB +: 3];
				end
			end
		end
	end

	// Output source select and input enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_output_select <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			in_enable <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
		end else if (wr_en) begin
			if (hit(paddr, pdm_pkg::OFF_HW_SEL)) begin
				hw_output_select <= pwdata[NUM_PINS-1:0];
			end else if (hit(paddr, pdm_pkg::OFF_IN_EN)) begin
				in_enable <= pwdata[NUM_PINS-1:0];
			end else if (pin_hit) begin
				hw_output_select[pin_index[2:0]] <= pwdata[pdm_pkg::PIN_HW_SEL_BIT];
				in_enable[pin_index[2:0]] <= pwdata[pdm_pkg::PIN_IN_EN_BIT];
			end
		end
	end

	// Regulated output and USB mode selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regulated <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			usb_enable <= 1'b0;
		end else if (wr_en) begin
			if (hit(paddr, pdm_pkg::OFF_REGULATED)) begin
				regulated <= pwdata[NUM_PINS-1:0] & SPECIAL_MASK[NUM_PINS-1:0];
			end
			if (hit(paddr, pdm_pkg::OFF_USB_EN)) begin
				usb_enable <= pwdata[0];
			end
		end
	end

	// Interrupt edge selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_rise <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			int_fall <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
		end else if (wr_en) begin
			if (hit(paddr, pdm_pkg::OFF_INT_RISE)) begin
				int_rise <= pwdata[NUM_PINS-1:0];
			end else if (hit(paddr, pdm_pkg::OFF_INT_FALL)) begin
				int_fall <= pwdata[NUM_PINS-1:0];
			end else if (pin_hit) begin
				int_rise[pin_index[2:0]] <= pwdata[pdm_pkg::PIN_RISE_BIT];
				int_fall[pin_index[2:0]] <= pwdata[pdm_pkg::PIN_FALL_BIT];
			end
		end
	end

	// Pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync1 <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			pin_sync2 <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
		end else if (ce) begin
			pin_sync1 <= pin_in;
			pin_sync2 <= pin_sync1;
		end
	end

	// Pin state, held at zero where the input buffer is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_state_reg <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			pin_state_prev <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
		end else if (ce) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				pin_state_reg[i] <= pin_sync2[i] & drive[i].in_en;
			end
			pin_state_prev <= pin_state_reg;
		end
	end

	assign edge_event = (int_rise & pin_state_reg & ~pin_state_prev) |
		(int_fall & ~pin_state_reg & pin_state_prev);

	// Interrupt status: a new edge wins over a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
		end else if (ce) begin
			if (rd_en && hit(paddr, pdm_pkg::OFF_INT_STATUS)) begin
				int_status <= edge_event;
			end else begin
				int_status <= int_status | edge_event;
			end
		end
	end

	// Drive decode per pin
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			assign port_output_value[g] = hw_output_select[g] ? sys_out[g] : output_value_reg[g];
			always_comb begin
				if (USB_MASK[g] && usb_enable) begin
					drive[g] = '0;
					drive[g].in_en = 1'b1;
					drive[g].strong_hi = !usb_tx_oe_n[g] && usb_tx_val[g];
					drive[g].strong_lo = !usb_tx_oe_n[g] && !usb_tx_val[g];
				end else if (USB_MASK[g]) begin
					drive[g] = decode_usb(drive_mode_field[g], port_output_value[g]);
				end else begin
					drive[g] = decode_mode(drive_mode_field[g], port_output_value[g], regulated[g]);
				end
			end
		end
	endgenerate

	// Registered pin drive and system input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			pin_oe_n <= '1;
			pin_pull_up <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			pin_pull_dn <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
			sys_in <= pdm_pkg::RESET_ZERO[NUM_PINS-1:0];
		end else if (ce) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				pin_out[i] <= drive[i].strong_hi;
				pin_oe_n[i] <= !(drive[i].strong_hi || drive[i].strong_lo);
				pin_pull_up[i] <= drive[i].res_hi;
				pin_pull_dn[i] <= drive[i].res_lo;
			end
			sys_in <= pin_state_reg & in_enable;
		end
	end

	assign port_irq = |int_status;

	// Per-pin view word
	always_comb begin
		pin_word = '0;
		if (pin_hit && pin_index < 8'(NUM_PINS)) begin
			pin_word[pdm_pkg::PIN_OUT_BIT] = output_value_reg[pin_index[2:0]];
			pin_word[pdm_pkg::PIN_DM_LSB +: 3] = drive_mode_field[pin_index[2:0]];
			pin_word[pdm_pkg::PIN_HW_SEL_BIT] = hw_output_select[pin_index[2:0]];
			pin_word[pdm_pkg::PIN_IN_EN_BIT] = in_enable[pin_index[2:0]];
			pin_word[pdm_pkg::PIN_STATE_BIT] = pin_state_reg[pin_index[2:0]];
			pin_word[pdm_pkg::PIN_RISE_BIT] = int_rise[pin_index[2:0]];
			pin_word[pdm_pkg::PIN_FALL_BIT] = int_fall[pin_index[2:0]];
		end
	end

	// Read mux
	always_comb begin
		prdata = '0;
		if (pin_hit) begin
			prdata = pin_word;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				unique case (1'b1)
					hit(paddr, pdm_pkg::OFF_OUT_VALUE): prdata[i] = output_value_reg[i];
					hit(paddr, pdm_pkg::OFF_PIN_STATE): prdata[i] = pin_state_reg[i];
					hit(paddr, pdm_pkg::OFF_DM0): prdata[i] = drive_mode_field[i][0];
					hit(paddr, pdm_pkg::OFF_DM1): prdata[i] = drive_mode_field[i][1];
					hit(paddr, pdm_pkg::OFF_DM2): prdata[i] = drive_mode_field[i][2];
					hit(paddr, pdm_pkg::OFF_HW_SEL): prdata[i] = hw_output_select[i];
					hit(paddr, pdm_pkg::OFF_IN_EN): prdata[i] = in_enable[i];
					hit(paddr, pdm_pkg::OFF_REGULATED): prdata[i] = regulated[i];
					hit(paddr, pdm_pkg::OFF_INT_RISE): prdata[i] = int_rise[i];
					hit(paddr, pdm_pkg::OFF_INT_FALL): prdata[i] = int_fall[i];
					hit(paddr, pdm_pkg::OFF_INT_STATUS): prdata[i] = int_status[i];
					default: prdata[i] = 1'b0;
				endcase
			end
			if (hit(paddr, pdm_pkg::OFF_USB_EN)) begin
				prdata[0] = usb_enable;
			end
		end
	end

endmodule

// [test/pdm_port_properties.sv]
// Checker of bus, drive and interrupt relations of the pin port
`timescale 1ns/10ps
module pdm_port_properties #(
	parameter int NUM_PINS = 8
) (
	// Clock and control
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and system
	input wire logic [NUM_PINS-1:0] sys_out,
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe_n,
	input wire logic [NUM_PINS-1:0] pin_pull_up,
	input wire logic [NUM_PINS-1:0] pin_pull_dn,
	input wire logic port_irq
);
	logic stat_rd;
	assign stat_rd = psel && penable && !pwrite && ce && paddr == pdm_pkg::OFF_INT_STATUS;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_ps_wr;
		psel && penable && pwrite && paddr == pdm_pkg::OFF_PIN_STATE && $stable(sys_out);
	endsequence
	// Pin change reaches the status bit after the synchroniser and state stage
	sequence s_pin_moved;
		$past(pin_in, 3) != $past(pin_in, 4) || $past(pin_in, 4) != $past(pin_in, 5);
	endsequence
	a_reset_float: assert property ($rose(presetn) |-> &pin_oe_n && !port_irq)
		else $error("pin driven or irq set after reset");
	a_strong_no_pull: assert property ((~pin_oe_n & (pin_pull_up | pin_pull_dn)) == '0)
		else $error("strong driver and pull on together");
	a_pull_one_side: assert property ((pin_pull_up & pin_pull_dn) == '0)
		else $error("both pulls on at once");
	a_zero_wait: assert property (psel && penable |-> pready && (!pslverr || prdata == 32'h0))
		else $error("bus answer late or error with data");
	a_ps_write_ignored: assert property (s_ps_wr |=> $stable(pin_oe_n) && $stable(pin_out))
		else $error("pin state write moved the outputs");
	a_irq_from_edge: assert property ($rose(port_irq) |-> s_pin_moved)
		else $error("irq without a pin edge");
	a_irq_hold: assert property (port_irq && !stat_rd |=> port_irq)
		else $error("irq dropped without status read");
	a_irq_clear_read: assert property ($fell(port_irq) |-> $past(stat_rd))
		else $error("irq cleared without status read");
endmodule
bind pdm_port pdm_port_properties #(.NUM_PINS(NUM_PINS)) u_props (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sys_out(sys_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
	.pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .port_irq(port_irq));

// [test/pdm_pin_model.sv]
// Far-side pin circuit: external driver, pulls and a floating level
`timescale 1ns/10ps
module pdm_pin_model (
	// Clock
	input wire logic pclk,
	// Port drive
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pin_pull_up,
	input wire logic [7:0] pin_pull_dn,
	// External circuit
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Level seen by the port
	output logic [7:0] pin_in
);
	logic tgl = 1'b0;
	// A floating pin keeps moving so no stale level is read
	always @(posedge pclk) tgl <= ~tgl;
	always_comb begin
		for (int i = 0; i < 8; i++)
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pull_up[i] ? 1'b1 :
				pin_pull_dn[i] ? 1'b0 : tgl;
	end
endmodule

// [test/pdm_port_test.sv]
// Self-checking bench of the pin drive-mode port
`timescale 1ns/10ps
module pdm_port_test;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, lk = 0;
	logic [7:0] paddr = 8'h00, sys_out = 8'h00, usb_tx_val = 8'h00, usb_tx_oe_n = 8'hFF;
	logic [7:0] ext_val = 8'h00, ext_en = 8'h00, msk, x;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, port_irq;
	logic [7:0] sys_in, pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_dn, ov;
	logic [2:0] dm [8];
	logic [32:0] rq [$];
	logic [11:0] dq [$];
	logic [32:0] e;
	logic [11:0] f;
	int error_cnt = 0, check_count = 0, cyc = 0, p = 0;
	// Drive codes: 0 float, 1 res high, 2 res low, 3 strong high, 4 strong low
	localparam logic [23:0] T1 = {3'h1, 3'h3, 3'h3, 3'h0, 3'h3, 3'h1, 3'h0, 3'h0};
	localparam logic [23:0] T0 = {3'h2, 3'h4, 3'h0, 3'h4, 3'h2, 3'h4, 3'h0, 3'h0};

	pdm_port #(.SPECIAL_MASK(8'h20), .RESET_OUT(8'h80)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_out(sys_out),
		.sys_in(sys_in), .usb_tx_val(usb_tx_val), .usb_tx_oe_n(usb_tx_oe_n), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .port_irq(port_irq));
	pdm_pin_model u_far (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
		.pin_pull_dn(pin_pull_dn), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

	initial begin
		forever #2 pclk = ~pclk;
	end

	function automatic logic [2:0] code(input int i);
		return !pin_oe_n[i] ? (pin_out[i] ? 3'h3 : 3'h4) : pin_pull_up[i] ? 3'h1 : pin_pull_dn[i] ? 3'h2 : 3'h0;
	endfunction

	function automatic logic [7:0] pl(input int k);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = dm[i][k];
		return r;
	endfunction

	task automatic summarize();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic ok);
		check_count++;
		if (!ok) begin
			error_cnt++;
			$display("unexpected at %0t: observed value differs", $time);
		end
	endtask

	// Result watcher: oldest note against each read and each look
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = rq.pop_front();
			chk({pslverr, prdata} === e);
		end
		if (lk) begin
			f = dq.pop_front();
			chk({port_irq, sys_in, code(p)} === f);
		end
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] v);
		rq.push_back(v);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic look(input logic [11:0] v);
		dq.push_back(v);
		lk <= 1'b1;
		@(posedge pclk);
		lk <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic pw(input logic [2:0] m, input logic d);
		apb(1'b1, pdm_pkg::OFF_OUT_VALUE, {24'h0, {8{d}}});
		apb(1'b1, pdm_pkg::OFF_DM0, {24'h0, {8{m[0]}}});
		apb(1'b1, pdm_pkg::OFF_DM1, {24'h0, {8{m[1]}}});
		apb(1'b1, pdm_pkg::OFF_DM2, {24'h0, {8{m[2]}}});
		ov = {8{d}};
		for (int i = 0; i < 6; i++) dm[i] = m;
	endtask

	task automatic pp(input int i, input logic [2:0] m, input logic d, input logic h);
		apb(1'b1, pdm_pkg::OFF_PIN_BASE + 8'(i * 4), {27'h0, h, m, d});
		dm[i] = m;
		ov[i] = d;
	endtask

	initial begin
		void'($urandom(59));
		for (int i = 0; i < 8; i++) dm[i] = 3'h0;
		ov = 8'h80;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		look({1'b0, 8'h00, 3'h0});
		rd(pdm_pkg::OFF_DM0, 33'h0);
		rd(pdm_pkg::OFF_OUT_VALUE, {25'h0, ov});
		$display("test reset done");
		for (int m = 0; m < 8; m++)
			for (int d = 0; d < 2; d++) begin
				p = $urandom % 6;
				if ((m + d) % 2) pp(p, 3'(m), 1'(d), 1'b0);
				else pw(3'(m), 1'(d));
				look({1'b0, 8'h00, d ? T1[m * 3 +: 3] : T0[m * 3 +: 3]});
				rd(pdm_pkg::OFF_DM1, {25'h0, pl(1)});
			end
		$display("test drive modes done");
		for (int k = 0; k < 4; k++) begin
			sys_out <= 8'($urandom);
			pp(p, pdm_pkg::DM_STRONG, 1'b0, 1'b1);
			look({1'b0, 8'h00, sys_out[p] ? 3'h3 : 3'h4});
		end
		$display("test output select done");
		ext_en <= 8'hFF;
		x = 8'($urandom) & 8'h3F;
		msk = 8'($urandom);
		ext_val <= x;
		pw(3'h1, 1'b0);
		apb(1'b1, pdm_pkg::OFF_IN_EN, {24'h0, msk});
		repeat (4) @(posedge pclk);
		rd(pdm_pkg::OFF_PIN_STATE, {25'h0, x});
		look({1'b0, x & msk, 3'h0});
		apb(1'b1, pdm_pkg::OFF_PIN_STATE, 32'hFF);
		rd(pdm_pkg::OFF_OUT_VALUE, 33'h0);
		rd(8'h30, {1'b1, 32'h0});
		pw(3'h0, 1'b0);
		repeat (4) @(posedge pclk);
		rd(pdm_pkg::OFF_PIN_STATE, 33'h0);
		look({1'b0, 8'h00, 3'h0});
		$display("test input path done");
		ext_val <= 8'h00;
		pw(3'h1, 1'b0);
		apb(1'b1, pdm_pkg::OFF_INT_RISE, 32'h05);
		apb(1'b1, pdm_pkg::OFF_INT_FALL, 32'h06);
		rd(pdm_pkg::OFF_INT_STATUS, 33'h0);
		ext_val <= 8'h07;
		repeat (6) @(posedge pclk);
		look({1'b1, 8'h07 & msk, 3'h0});
		rd(pdm_pkg::OFF_INT_STATUS, {25'h0, 8'h05});
		rd(pdm_pkg::OFF_INT_STATUS, 33'h0);
		ext_val <= 8'h00;
		repeat (6) @(posedge pclk);
		rd(pdm_pkg::OFF_INT_STATUS, {25'h0, 8'h06});
		look({1'b0, 8'h00, 3'h0});
		ce <= 1'b0;
		apb(1'b1, pdm_pkg::OFF_INT_RISE, 32'hFF);
		ce <= 1'b1;
		rd(pdm_pkg::OFF_INT_RISE, {25'h0, 8'h05});
		$display("test interrupts done");
		apb(1'b1, pdm_pkg::OFF_REGULATED, 32'hFF);
		rd(pdm_pkg::OFF_REGULATED, {25'h0, 8'h20});
		p = 5;
		pp(5, pdm_pkg::DM_RES_BOTH, 1'b1, 1'b0);
		look({1'b0, 8'h00, 3'h0});
		pp(5, pdm_pkg::DM_RES_DOWN, 1'b0, 1'b0);
		look({1'b0, 8'h00, 3'h0});
		pp(5, pdm_pkg::DM_RES_DOWN, 1'b1, 1'b0);
		look({1'b0, 8'h00, 3'h3});
		$display("test regulated pins done");
		p = 6;
		for (int m = 0; m < 4; m++)
			for (int d = 0; d < 2; d++) begin
				pp(6, 3'(m), 1'(d), 1'b0);
				look({1'b0, 8'h00, m[0] ? (d ? 3'h3 : 3'h4) : (m[1] && d) ? 3'h1 : d ? 3'h0 : 3'h4});
			end
		pp(6, 3'h2, 1'b1, 1'b0);
		apb(1'b1, pdm_pkg::OFF_USB_EN, 32'h1);
		usb_tx_oe_n <= 8'hBF;
		usb_tx_val <= 8'($urandom);
		repeat (2) @(posedge pclk);
		look({1'b0, 8'h00, usb_tx_val[6] ? 3'h3 : 3'h4});
		rd(pdm_pkg::OFF_PIN_BASE + 8'h18, {24'h0, 2'b00, usb_tx_val[6], 2'b00, dm[6], ov[6]});
		$display("test usb pins done");
		summarize();
	end
endmodule
